/* core/sbcs_sequencer.v */
// Mode sequencer: power-up, watchdog arming and regulator fault handling.
// Assumes the serial interface gives one-cycle write strobes in clk domain.
// How it works
// - Four status bits mirror supply low, switch hot, temp warn, bus fail.
// - Power-up enters normal-request: main on, secondary off, bus TX/RX.
// - No timing write within 350 ms in normal-request gives a reset.
// - The watchdog-fault output is held low until the first timing write or an under-voltage.
// - The first timing write enters normal mode with all supplies up.
// - A missed refresh in normal mode resets back to normal-request.
// - Under-voltage with stop selected enters reset, int low, fault high.
// - When that fault clears the device restarts in normal-request.
// - Under-voltage with sleep selected, battery flag clear holds 100 ms.
// - After those 100 ms the device sleeps with both supplies off.
// - A masked-in status condition drives the interrupt output low, except in sleep, where the output keeps its value.
`timescale 1ns/1ps
`include "sbcs_consts.vh"
module sbcs_sequencer
#(
   parameter ARM_TIMEOUT_CYC = `SBCS_ARM_TIMEOUT_CYC,
   parameter SLEEP_RESET_CYC = `SBCS_SLEEP_RESET_CYC,
   parameter RST_PULSE_CYC = `SBCS_RST_PULSE_CYC
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire supply_low_pin,
   input wire highside_overtemp_pin,
   input wire main_reg_temp_pin,
   input wire bus_failure_pin,
   input wire main_reg_undervolt_pin,
   input wire watchdog_timing_wr,
   input wire watchdog_refresh_missed,
   input wire lowpower_sleep_sel,
   input wire battery_fail_flag,
   input wire mask_wr,
   input wire [3:0] mask_wdata,
   output reg [3:0] interrupt_source_status,
   output reg reset_out_n,
   output reg interrupt_out_n,
   output reg watchdog_fault_out,
   output reg main_reg_on,
   output reg secondary_tracking_supply,
   output reg transmit_receive,
   output reg [4:0] mode_state
);
   localparam S_NREQ = 5'h01;
   localparam S_NORM = 5'h02;
   localparam S_RSTP = 5'h04;
   localparam S_UVRST = 5'h08;
   localparam S_SLEEP = 5'h10;

   ////////////////////////////////////////////////////////////////////
   wire [4:0] cond;
   reg [3:0] mask;
   reg [31:0] timer;
   reg [31:0] next_timer;
   reg [4:0] next_state;
   reg uv_sleep_path;
   reg next_uv_sleep_path;
   wire uv;
   wire [3:0] flags;

   // Interrupt level for a set of conditions and a mask, active low.
   // Shared by every mode that lets the mask decide the pin.
   function int_level_n;
      input [3:0] f;
      input [3:0] m;
      begin
         int_level_n = ~|(f & m);
      end
   endfunction

   sbcs_sync #(.WIDTH(5)) u_sync
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .async_in({main_reg_undervolt_pin, supply_low_pin,
                 highside_overtemp_pin, main_reg_temp_pin,
                 bus_failure_pin}),
      .sync_out(cond)
   );

   assign uv = cond[4];
   assign flags = cond[3:0];

   ////////////////////////////////////////////////////////////////////
   // Next-state logic. Under-voltage outranks watchdog events, since a
   // dead main regulator makes the host's writes meaningless.
   always @*
   begin
      next_state = mode_state;
      next_timer = timer + 32'h1;
      next_uv_sleep_path = uv_sleep_path;
      case (mode_state)
         S_NREQ, S_NORM:
         begin
            if (uv)
            begin
               next_state = S_UVRST;
               next_timer = 32'h0;
               // Sleep path only when the battery flag is clear.
               next_uv_sleep_path = lowpower_sleep_sel &
                                    ~battery_fail_flag;
            end
            else if (mode_state == S_NREQ && watchdog_timing_wr)
            begin
               next_state = S_NORM;
               next_timer = 32'h0;
            end
            else if (mode_state == S_NREQ &&
                     timer >= ARM_TIMEOUT_CYC - 1)
            begin
               next_state = S_RSTP;
               next_timer = 32'h0;
            end
            else if (mode_state == S_NORM && watchdog_refresh_missed)
            begin
               next_state = S_RSTP;
               next_timer = 32'h0;
            end
            else if (mode_state == S_NORM)
               next_timer = 32'h0;
         end
         S_RSTP:
         begin
            if (timer >= RST_PULSE_CYC - 1)
            begin
               next_state = S_NREQ;
               next_timer = 32'h0;
            end
         end
         S_UVRST:
         begin
            if (uv_sleep_path)
            begin
               if (timer >= SLEEP_RESET_CYC - 1)
                  next_state = S_SLEEP;
            end
            else if (!uv)
            begin
               next_state = S_NREQ;
               next_timer = 32'h0;
            end
         end
         S_SLEEP:
            next_timer = timer;
         default:
         begin
            next_state = S_NREQ;
            next_timer = 32'h0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs are registered from the next state so they track the mode
   // with no extra cycle of lag.
   always @(posedge clk)
   begin
      if (rst)
      begin
         mode_state <= S_NREQ;
         timer <= 32'h0;
         uv_sleep_path <= 1'b0;
         mask <= `SBCS_MASK_RESET;
         interrupt_source_status <= `SBCS_STATUS_RESET;
         reset_out_n <= 1'b0;
         interrupt_out_n <= 1'b1;
         watchdog_fault_out <= 1'b0;
         main_reg_on <= 1'b1;
         secondary_tracking_supply <= 1'b0;
         transmit_receive <= 1'b1;
      end
      else if (ce)
      begin
         mode_state <= next_state;
         timer <= next_timer;
         uv_sleep_path <= next_uv_sleep_path;
         if (mask_wr)
            mask <= mask_wdata;
         interrupt_source_status <= flags;
         case (next_state)
            S_NREQ:
            begin
               reset_out_n <= 1'b1;
               watchdog_fault_out <= 1'b0;
               main_reg_on <= 1'b1;
               secondary_tracking_supply <= 1'b0;
               transmit_receive <= 1'b1;
               interrupt_out_n <= int_level_n(flags, mask);
            end
            S_NORM:
            begin
               reset_out_n <= 1'b1;
               watchdog_fault_out <= 1'b1;
               main_reg_on <= 1'b1;
               secondary_tracking_supply <= 1'b1;
               transmit_receive <= 1'b1;
               interrupt_out_n <= int_level_n(flags, mask);
            end
            S_RSTP:
            begin
               reset_out_n <= 1'b0;
               watchdog_fault_out <= 1'b0;
               secondary_tracking_supply <= 1'b0;
               interrupt_out_n <= int_level_n(flags, mask);
            end
            S_UVRST:
            begin
               reset_out_n <= 1'b0;
               interrupt_out_n <= 1'b0;
               watchdog_fault_out <= 1'b1;
            end
            S_SLEEP:
            begin
               main_reg_on <= 1'b0;
               secondary_tracking_supply <= 1'b0;
               transmit_receive <= 1'b0;
            end
            default:
               reset_out_n <= 1'b0;
         endcase
      end
   end
endmodule

/* core/sbcs_consts.vh */
// Constants for the power-up and fault sequencer.
// Assumes a 100 MHz core clock; included by its bare name.
`ifndef SBCS_CONSTS_VH
`define SBCS_CONSTS_VH
`define SBCS_CLK_HZ 100000000
`define SBCS_ARM_TIMEOUT_MS 350
`define SBCS_ARM_TIMEOUT_CYC (`SBCS_ARM_TIMEOUT_MS * (`SBCS_CLK_HZ / 1000))
`define SBCS_SLEEP_RESET_MS 100
`define SBCS_SLEEP_RESET_CYC (`SBCS_SLEEP_RESET_MS * (`SBCS_CLK_HZ / 1000))
`define SBCS_RST_PULSE_CYC 16
`define SBCS_ST_SUPPLY_LOW 3
`define SBCS_ST_HS_OVERTEMP 2
`define SBCS_ST_TEMP_WARN 1
`define SBCS_ST_BUS_FAIL 0
`define SBCS_STATUS_RESET 4'h0
`define SBCS_MASK_RESET 4'h0
`define SBCS_LP_STOP 1'b0
`define SBCS_LP_SLEEP 1'b1
`endif

/* core/sbcs_sync.v */
// Two-flop synchroniser bank for asynchronous condition inputs.
// Assumes the inputs are levels from outside the clock domain.
`timescale 1ns/1ps
module sbcs_sync
#(
   parameter WIDTH = 8
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta;
   always @(posedge clk)
   begin
      if (rst)
      begin
         meta <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else if (ce)
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* verif/sbcs_seq_props.sv */
// Concurrent checks on the mode sequencer ports.
// Assumes the bench sets the reset pulse to four cycles.
`timescale 1ns/1ps
module sbcs_seq_props
#(
   parameter ARM_TIMEOUT_CYC = 100
)
(
   input wire clk,
   input wire rst,
   input wire ce,
   input wire main_reg_undervolt_pin,
   input wire watchdog_timing_wr,
   input wire watchdog_refresh_missed,
   input wire lowpower_sleep_sel,
   input wire mask_wr,
   input wire [3:0] mask_wdata,
   input wire [3:0] interrupt_source_status,
   input wire reset_out_n,
   input wire interrupt_out_n,
   input wire watchdog_fault_out,
   input wire main_reg_on,
   input wire secondary_tracking_supply,
   input wire [4:0] mode_state
);
reg [1:0] uvh;
reg [3:0] mk = 4'h0;
reg [3:0] mk2 = 4'h0;
integer t01 = 0;
// Three low samples mean the synchronised fault is surely gone.
wire uvq = uvh == 2'h0 && !main_reg_undervolt_pin;
always @(posedge clk)
begin
   uvh <= {uvh[0], main_reg_undervolt_pin};
   mk2 <= mk;
   t01 <= (mode_state == 5'h01 && !rst) ? t01 + 1 : 0;
   if (rst)
      mk <= 4'h0;
   else if (mask_wr)
      mk <= mask_wdata;
end
////////////////////////////////////////
default clocking cb @(posedge clk); endclocking
default disable iff (rst || !ce);
sequence s_pulse;
   (mode_state == 5'h04 && !reset_out_n && !watchdog_fault_out) [*4]
   ##1 mode_state == 5'h01;
endsequence
sequence s_armed;
   mode_state == 5'h02 && watchdog_fault_out && secondary_tracking_supply
   && reset_out_n;
endsequence
chk_arm_enters_normal: assert property (
   mode_state == 5'h01 && watchdog_timing_wr && uvq |=> s_armed)
   else $error("arming write did not reach normal mode");
chk_watchdog_fault_out_held_low: assert property (
   mode_state == 5'h01 |-> !watchdog_fault_out)
   else $error("fault output released before arming");
chk_timeout_bound: assert property (
   mode_state == 5'h01 |-> t01 <= ARM_TIMEOUT_CYC + 2)
   else $error("arming wait overran its limit");
chk_reset_pulse: assert property (
   $rose(mode_state == 5'h04) |-> s_pulse)
   else $error("watchdog reset pulse malformed");
chk_missed_refresh: assert property (
   mode_state == 5'h02 && watchdog_refresh_missed && uvq
   |=> mode_state == 5'h04)
   else $error("missed refresh gave no reset");
chk_uv_outputs: assert property (
   mode_state == 5'h08
   |-> !reset_out_n && !interrupt_out_n && watchdog_fault_out)
   else $error("wrong outputs in fault reset");
chk_stop_restart: assert property (
   mode_state == 5'h08 && !lowpower_sleep_sel && uvq |=> mode_state == 5'h01)
   else $error("no restart after fault cleared");
chk_sleep_off: assert property (
   mode_state == 5'h10 |-> !main_reg_on && !secondary_tracking_supply)
   else $error("supplies on in sleep");
chk_int_masked: assert property (
   mode_state == 5'h02 && $past(mode_state) == 5'h02
   && (interrupt_source_status & mk & mk2) != 4'h0 |-> !interrupt_out_n)
   else $error("masked-in condition left interrupt high");
endmodule
bind sbcs_sequencer sbcs_seq_props
   #(.ARM_TIMEOUT_CYC(ARM_TIMEOUT_CYC)) u_props
(
   .clk(clk),
   .rst(rst),
   .ce(ce),
   .main_reg_undervolt_pin(main_reg_undervolt_pin),
   .watchdog_timing_wr(watchdog_timing_wr),
   .watchdog_refresh_missed(watchdog_refresh_missed),
   .lowpower_sleep_sel(lowpower_sleep_sel),
   .mask_wr(mask_wr),
   .mask_wdata(mask_wdata),
   .interrupt_source_status(interrupt_source_status),
   .reset_out_n(reset_out_n),
   .interrupt_out_n(interrupt_out_n),
   .watchdog_fault_out(watchdog_fault_out),
   .main_reg_on(main_reg_on),
   .secondary_tracking_supply(secondary_tracking_supply),
   .mode_state(mode_state)
);

/* verif/sbcs_host_model.sv */
// Host side: arms the watchdog once reset is released.
// Assumes the bench holds arm_req until normal mode shows.
`timescale 1ns/1ps
module sbcs_host_model
#(
   parameter DELAY = 3
)
(
   input wire clk,
   input wire arm_req,
   input wire reset_out_n,
   output reg watchdog_timing_wr
);
integer n = 0;
initial watchdog_timing_wr = 1'b0;
always @(posedge clk)
begin
   // One strobe per reset release, issued after DELAY cycles with arm_req high.
   watchdog_timing_wr <= reset_out_n && arm_req && n == DELAY;
   if (!reset_out_n)
      n <= 0;
   else if (arm_req && n <= DELAY)
      n <= n + 1;
end
endmodule

/* verif/test_sbcs_sequencer.sv */
// Directed bench for the mode sequencer with a host model.
// Assumes shortened counts: arm 100, sleep hold 50, pulse 4.
`timescale 1ns/1ps
module test_sbcs_sequencer;
reg clk = 0, rst = 1, ce = 1, main_reg_undervolt_pin = 0, arm_req = 0;
reg supply_low_pin = 0, highside_overtemp_pin = 0, main_reg_temp_pin = 0;
reg bus_failure_pin = 0, watchdog_refresh_missed = 0, mask_wr = 0;
reg lowpower_sleep_sel = 0, battery_fail_flag = 0;
reg [3:0] mask_wdata = 4'h0;
wire watchdog_timing_wr, reset_out_n, interrupt_out_n, watchdog_fault_out;
wire main_reg_on, secondary_tracking_supply, transmit_receive;
wire [3:0] interrupt_source_status;
wire [4:0] mode_state;
wire [4:0] outs = {main_reg_on, secondary_tracking_supply,
   transmit_receive, watchdog_fault_out, reset_out_n};
wire [2:0] fault_pins = {reset_out_n, interrupt_out_n, watchdog_fault_out};
wire [4:0] stat_int = {interrupt_source_status, interrupt_out_n};
integer errors = 0, n_tests = 0, cyc = 0, k, i;
sbcs_sequencer #(.ARM_TIMEOUT_CYC(100), .SLEEP_RESET_CYC(50),
   .RST_PULSE_CYC(4)) u_dut (.*);
sbcs_host_model u_host (.clk(clk), .arm_req(arm_req),
   .reset_out_n(reset_out_n), .watchdog_timing_wr(watchdog_timing_wr));
initial forever #5 clk = ~clk;
task chk(input string what, input [4:0] seen, input [4:0] exp);
begin
   n_tests = n_tests + 1;
   if (seen !== exp)
   begin
      errors = errors + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
   end
end
endtask
task stop_test;
begin
   $display("Checks %0d errors %0d", n_tests, errors);
   if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
   else
      $display("Finished with errors");
   $finish;
end
endtask
task step(input integer n);
begin
   repeat (n) @(posedge clk);
   #1;
end
endtask
task wait_mode(input [4:0] m);
begin
   for (k = 0; mode_state !== m && k < 300; k = k + 1)
      step(1);
end
endtask
task arm;
begin
   arm_req = 1;
   wait_mode(5'h02);
   arm_req = 0;
end
endtask
task set_mask(input [3:0] m);
begin
   mask_wr = 1;
   mask_wdata = m;
   step(1);
   mask_wr = 0;
   step(2);
end
endtask
task uv_case(input sel, input bat, input [4:0] after);
begin
   arm;
   lowpower_sleep_sel = sel;
   battery_fail_flag = bat;
   main_reg_undervolt_pin = 1;
   wait_mode(5'h08);
   chk("uv pins", fault_pins, 5'h01);
   step(45);
   chk("uv hold", mode_state, 5'h08);
   if (sel && !bat)
      step(10);
   else
   begin
      main_reg_undervolt_pin = 0;
      step(5);
   end
   chk("uv exit", mode_state, after);
end
endtask
always @(posedge clk)
begin
   cyc = cyc + 1;
   if (cyc == 3000)
   begin
      errors = errors + 1;
      stop_test;
   end
end
initial
begin
   step(6);
   rst = 0;
   step(2);
   chk("start state", mode_state, 5'h01);
   chk("start outs", outs, 5'h15);
   for (k = 2; reset_out_n === 1'b1 && k < 300; k = k + 1)
      step(1);
   chk("arm timeout", k >= 98 && k <= 104, 1);
   chk("pulse fault", watchdog_fault_out, 0);
   wait_mode(5'h01);
   arm;
   chk("normal outs", outs, 5'h1F);
   watchdog_refresh_missed = 1;
   step(1);
   watchdog_refresh_missed = 0;
   wait_mode(5'h04);
   chk("missed", k <= 2 && !reset_out_n, 1);
   wait_mode(5'h01);
   arm;
   for (i = 0; i < 4; i = i + 1)
   begin
      set_mask(~(4'h1 << i));
      {supply_low_pin, highside_overtemp_pin, main_reg_temp_pin,
         bus_failure_pin} = 4'h1 << i;
      step(4);
      chk("status", interrupt_source_status, 4'h1 << i);
      chk("int unmasked", interrupt_out_n, 1);
      set_mask(4'h1 << i);
      chk("int masked", interrupt_out_n, 0);
      {supply_low_pin, highside_overtemp_pin, main_reg_temp_pin,
         bus_failure_pin} = 4'h0;
      step(4);
      chk("status clear", stat_int, 5'h01);
   end
   // With the clock enable low a new condition must not reach the status.
   ce = 0;
   bus_failure_pin = 1;
   step(6);
   chk("ce freeze", stat_int, 5'h01);
   ce = 1;
   bus_failure_pin = 0;
   step(4);
   uv_case(0, 0, 5'h01);
   uv_case(1, 1, 5'h01);
   uv_case(1, 0, 5'h10);
   chk("sleep outs", {main_reg_on, secondary_tracking_supply}, 0);
   stop_test;
end
endmodule
